// File: design/dac_path_pkg.sv
package dac_path_pkg;

  // ******************************************************************
  // register indices
  // ******************************************************************
  localparam logic [7:0] ADDR_POWER_MANAGEMENT_4    = 8'h0B;
  localparam logic [7:0] ADDR_CONVERTER_CONTROL     = 8'h30;
  localparam logic [7:0] ADDR_LEFT_DIGITAL_VOLUME   = 8'h32;
  localparam logic [7:0] ADDR_RIGHT_DIGITAL_VOLUME  = 8'h33;
  localparam logic [7:0] ADDR_SOFT_MUTE_CONTROL     = 8'h3A;
  localparam logic [7:0] ADDR_MUTE_RAMP_FILTER_CFG  = 8'h3B;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int BIT_PM_LEFT_ENABLE  = 4;
  localparam int BIT_PM_RIGHT_ENABLE = 5;
  localparam int BIT_VOL_ENABLE      = 15;
  localparam int BIT_VOL_UPDATE      = 8;
  localparam int VOL_CODE_HI         = 7;
  localparam int BIT_SOFT_MUTE       = 14;
  localparam int BIT_RAMPED_UNMUTE   = 14;
  localparam int BIT_RAMP_RATE_SLOW  = 13;
  localparam int BIT_SLOPING_STOP    = 12;
  localparam int BIT_MONO_MIX        = 13;
  localparam int DEEMPH_HI           = 5;
  localparam int DEEMPH_LO           = 4;
  localparam int BIT_LEFT_INVERT     = 1;
  localparam int BIT_RIGHT_INVERT    = 0;

  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [7:0] VOL_RESET       = 8'hC0;
  localparam logic       SOFT_MUTE_RESET = 1'h1;

  // ******************************************************************
  // gain and ramp
  // ******************************************************************
  localparam logic [7:0] GAIN_MUTE_CODE  = 8'h00;
  localparam logic [7:0] GAIN_UNITY_CODE = 8'hC0;
  localparam int         MANT_FRAC_BITS  = 15;
  localparam int         RAMP_DIV_FAST   = 2;
  localparam int         RAMP_DIV_SLOW   = 32;
  localparam logic [4:0] RAMP_LAST_FAST  = 5'(RAMP_DIV_FAST - 1);
  localparam logic [4:0] RAMP_LAST_SLOW  = 5'(RAMP_DIV_SLOW - 1);

  // one 6 dB octave split into 16 steps of 0.375 dB, q1.15
  localparam logic [15:0] GAIN_MANTISSA [16] = '{
    16'h8000, 16'h7A99, 16'h756B, 16'h7076, 16'h6BB5, 16'h6729, 16'h62CD, 16'h5EA0,
    16'h5AA0, 16'h56CC, 16'h5321, 16'h4F9E, 16'h4C41, 16'h4908, 16'h45F1, 16'h42FD
  };

endpackage

// File: design/volume_scaler.sv
`timescale 1ns/1ps

module volume_scaler
#(
  parameter int W = 24
)
(
  // sample and gain code
  input  logic signed [W-1:0] sample_in,
  input  logic        [7:0]   code,
  // scaled sample
  output logic signed [W-1:0] sample_out
);
  import dac_path_pkg::*;

  logic        [7:0]    steps;
  logic        [3:0]    octave;
  logic        [3:0]    fine;
  logic signed [W+16:0] prod;
  logic signed [W+16:0] shifted;

  // ******************************************************************
  // code to gain: 0.375 dB steps below unity
  // ******************************************************************
  always_comb
  begin
    steps   = GAIN_UNITY_CODE - code;
    octave  = steps[7:4];
    fine    = steps[3:0];
    prod    = sample_in * $signed({1'h0, GAIN_MANTISSA[fine]});
    shifted = prod >>> (MANT_FRAC_BITS + int'(octave));
    if (code == GAIN_MUTE_CODE)
      sample_out = '0;
    else if (code >= GAIN_UNITY_CODE)
      sample_out = sample_in;
    else
      sample_out = shifted[W-1:0];
  end

endmodule

// File: design/stereo_dac_digital_path.sv
`timescale 1ns/1ps

// Overview of operation
// - two enable bits, each at two addresses
// - 8-bit volume, zero mutes, 0xC0 unity
// - volume codes apply together on update bit
// - soft mute ramps gain down to silence
// - soft mute resets set; host clears it
// - mode zero unmute jumps to volume
// - mode one unmute ramps up to volume
// - rate bit picks fs/2 or fs/32
// - full ramp within 10.7 ms or 171 ms at 48 kHz
// - two-bit de-emphasis selection field
// - mono sums, halves, feeds both channels when both channels are enabled
// - per-channel polarity inversion bits
// - filter select normal or sloping stopband
// - 24-bit samples through the path
// - runs at any rate 8 to 48 kHz
module stereo_dac_digital_path
#(
  parameter int W = 24
)
(
  // clock, reset, enable
  input  logic                core_clk,
  input  logic                reset_n,
  input  logic                clk_en,
  // register port
  input  logic                reg_wr,
  input  logic                reg_rd,
  input  logic        [7:0]   reg_addr,
  input  logic        [15:0]  reg_wdata,
  output logic        [15:0]  reg_rdata,
  output logic                reg_rvalid,
  // samples from the audio interface
  input  logic                in_valid,
  input  logic signed [W-1:0] in_left,
  input  logic signed [W-1:0] in_right,
  // samples to the interpolation filters
  output logic                out_valid,
  output logic signed [W-1:0] out_left,
  output logic signed [W-1:0] out_right,
  // filter and converter controls
  output logic                left_conv_enable,
  output logic                right_conv_enable,
  output logic        [1:0]   deemphasis_select,
  output logic                sloping_stopband_select
);
  import dac_path_pkg::*;

  typedef struct packed {
    logic                left_en;
    logic                right_en;
    logic                mono;
    logic                inv_l;
    logic                inv_r;
    logic                mute;
    logic                ramp_mode;
    logic                rate_slow;
    logic                sb_filt;
    logic        [1:0]   deemph;
    logic        [7:0]   pend_l;
    logic        [7:0]   pend_r;
    logic        [7:0]   vol_l;
    logic        [7:0]   vol_r;
    logic        [7:0]   cur_l;
    logic        [7:0]   cur_r;
    logic        [4:0]   tick_cnt;
    logic        [15:0]  rdata;
    logic                rvalid;
    logic signed [W-1:0] out_l;
    logic signed [W-1:0] out_r;
    logic                out_v;
  } state_t;

  state_t              s_q;
  state_t              s_d;
  logic        [15:0]  read_word;
  logic                ramp_tick;
  logic        [4:0]   ramp_last;
  logic                mono_active;
  logic signed [W:0]   mono_sum;
  logic signed [W-1:0] mix_l;
  logic signed [W-1:0] mix_r;
  logic signed [W-1:0] scaled_l;
  logic signed [W-1:0] scaled_r;

  localparam logic signed [W-1:0] SAMPLE_MIN = {1'h1, {(W-1){1'h0}}};
  localparam logic signed [W-1:0] SAMPLE_MAX = {1'h0, {(W-1){1'h1}}};

  // ******************************************************************
  // helpers
  // ******************************************************************
  function automatic logic signed [W-1:0] polarity(input logic signed [W-1:0] x,
                                                    input logic inv);
    if (!inv)
      return x;
    else
      return (x == SAMPLE_MIN) ? SAMPLE_MAX : -x;
  endfunction
  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
    if (cur < tgt)
      return cur + 8'h01;
    else
      return (cur > tgt) ? cur - 8'h01 : cur;
  endfunction
  // ******************************************************************
  // mixing and gain
  // ******************************************************************
  // mono only with both channels on
  assign mono_active = s_q.mono & s_q.left_en & s_q.right_en;
  assign mono_sum    = in_left + in_right;
  assign mix_l       = mono_active ? mono_sum[W:1] : in_left;
  assign mix_r       = mono_active ? mono_sum[W:1] : in_right;

  volume_scaler #(.W(W)) u_scale_left
  (
    .sample_in  (mix_l),
    .code       (s_q.cur_l),
    .sample_out (scaled_l)
  );
  volume_scaler #(.W(W)) u_scale_right
  (
    .sample_in  (mix_r),
    .code       (s_q.cur_r),
    .sample_out (scaled_r)
  );

  // ******************************************************************
  // ramp timing
  // ******************************************************************
  // fs/2 or fs/32 step rate
  assign ramp_last = s_q.rate_slow ? RAMP_LAST_SLOW : RAMP_LAST_FAST;
  // at most 255 steps per ramp
  assign ramp_tick = in_valid & (s_q.tick_cnt >= ramp_last);

  // ******************************************************************
  // read mux
  // ******************************************************************
  always_comb
  begin
    read_word = 16'h0000;
    case (reg_addr)
      ADDR_POWER_MANAGEMENT_4:
      begin
        read_word[BIT_PM_LEFT_ENABLE]  = s_q.left_en;
        read_word[BIT_PM_RIGHT_ENABLE] = s_q.right_en;
      end
      ADDR_LEFT_DIGITAL_VOLUME:
      begin
        read_word[BIT_VOL_ENABLE]      = s_q.left_en;
        read_word[VOL_CODE_HI:0]       = s_q.pend_l;
      end
      ADDR_RIGHT_DIGITAL_VOLUME:
      begin
        read_word[BIT_VOL_ENABLE]      = s_q.right_en;
        read_word[VOL_CODE_HI:0]       = s_q.pend_r;
      end
      ADDR_CONVERTER_CONTROL:
      begin
        read_word[BIT_MONO_MIX]        = s_q.mono;
        read_word[DEEMPH_HI:DEEMPH_LO] = s_q.deemph;
        read_word[BIT_LEFT_INVERT]     = s_q.inv_l;
        read_word[BIT_RIGHT_INVERT]    = s_q.inv_r;
      end
      ADDR_SOFT_MUTE_CONTROL:
        read_word[BIT_SOFT_MUTE]       = s_q.mute;
      ADDR_MUTE_RAMP_FILTER_CFG:
      begin
        read_word[BIT_RAMPED_UNMUTE]   = s_q.ramp_mode;
        read_word[BIT_RAMP_RATE_SLOW]  = s_q.rate_slow;
        read_word[BIT_SLOPING_STOP]    = s_q.sb_filt;
      end
      default: read_word = 16'h0000;
    endcase
  end

  // ******************************************************************
  // next state
  // ******************************************************************
  always_comb
  begin
    s_d = s_q;
    if (clk_en)
    begin
      s_d.rvalid = 1'h0;
      s_d.out_v  = 1'h0;
      if (reg_rd)
      begin
        s_d.rdata  = read_word;
        s_d.rvalid = 1'h1;
      end
      if (reg_wr)
      begin
        case (reg_addr)
          ADDR_POWER_MANAGEMENT_4:
          begin
            s_d.left_en  = reg_wdata[BIT_PM_LEFT_ENABLE];
            s_d.right_en = reg_wdata[BIT_PM_RIGHT_ENABLE];
          end
          // hold code, apply both on update
          ADDR_LEFT_DIGITAL_VOLUME:
          begin
            s_d.left_en = reg_wdata[BIT_VOL_ENABLE];
            s_d.pend_l  = reg_wdata[VOL_CODE_HI:0];
            if (reg_wdata[BIT_VOL_UPDATE])
            begin
              s_d.vol_l = reg_wdata[VOL_CODE_HI:0];
              s_d.vol_r = s_q.pend_r;
            end
          end
          ADDR_RIGHT_DIGITAL_VOLUME:
          begin
            s_d.right_en = reg_wdata[BIT_VOL_ENABLE];
            s_d.pend_r   = reg_wdata[VOL_CODE_HI:0];
            if (reg_wdata[BIT_VOL_UPDATE])
            begin
              s_d.vol_r = reg_wdata[VOL_CODE_HI:0];
              s_d.vol_l = s_q.pend_l;
            end
          end
          ADDR_CONVERTER_CONTROL:
          begin
            s_d.mono   = reg_wdata[BIT_MONO_MIX];
            s_d.deemph = reg_wdata[DEEMPH_HI:DEEMPH_LO];
            s_d.inv_l  = reg_wdata[BIT_LEFT_INVERT];
            s_d.inv_r  = reg_wdata[BIT_RIGHT_INVERT];
          end
          ADDR_SOFT_MUTE_CONTROL:
            s_d.mute = reg_wdata[BIT_SOFT_MUTE];
          ADDR_MUTE_RAMP_FILTER_CFG:
          begin
            s_d.ramp_mode = reg_wdata[BIT_RAMPED_UNMUTE];
            s_d.rate_slow = reg_wdata[BIT_RAMP_RATE_SLOW];
            s_d.sb_filt   = reg_wdata[BIT_SLOPING_STOP];
          end
          default: s_d.rvalid = s_d.rvalid;
        endcase
      end
      if (in_valid)
        s_d.tick_cnt = ramp_tick ? 5'h00 : s_q.tick_cnt + 5'h01;
      if (s_q.mute || s_q.ramp_mode)
      begin
        if (ramp_tick)
        begin
          s_d.cur_l = step_toward(s_q.cur_l, s_q.mute ? GAIN_MUTE_CODE : s_q.vol_l);
          s_d.cur_r = step_toward(s_q.cur_r, s_q.mute ? GAIN_MUTE_CODE : s_q.vol_r);
        end
      end
      else
      begin
        s_d.cur_l = s_q.vol_l;
        s_d.cur_r = s_q.vol_r;
      end
      if (in_valid)
      begin
        s_d.out_l = s_q.left_en  ? polarity(scaled_l, s_q.inv_l) : '0;
        s_d.out_r = s_q.right_en ? polarity(scaled_r, s_q.inv_r) : '0;
        s_d.out_v = 1'h1;
      end
    end
  end

  // ******************************************************************
  // state register
  // ******************************************************************
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q        <= '0;
      s_q.mute   <= SOFT_MUTE_RESET;
      s_q.pend_l <= VOL_RESET;
      s_q.pend_r <= VOL_RESET;
      s_q.vol_l  <= VOL_RESET;
      s_q.vol_r  <= VOL_RESET;
    end
    else
      s_q <= s_d;
  end

  assign reg_rdata               = s_q.rdata;
  assign reg_rvalid              = s_q.rvalid;
  assign out_valid               = s_q.out_v;
  assign out_left                = s_q.out_l;
  assign out_right               = s_q.out_r;
  assign left_conv_enable        = s_q.left_en;
  assign right_conv_enable       = s_q.right_en;
  assign deemphasis_select       = s_q.deemph;
  assign sloping_stopband_select = s_q.sb_filt;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_enable_alias: assert property (clk_en && reg_wr && reg_addr == ADDR_RIGHT_DIGITAL_VOLUME
    |=> right_conv_enable == $past(reg_wdata[BIT_VOL_ENABLE])) else $error("enable alias lost");
  a_zero_silent: assert property (clk_en && in_valid && s_q.cur_l == 8'h00
    |=> out_left == '0) else $error("code zero not silent");
  a_volume_held: assert property (clk_en && reg_wr && reg_addr == ADDR_LEFT_DIGITAL_VOLUME
    && !reg_wdata[BIT_VOL_UPDATE] |=> $stable(s_q.vol_l) && $stable(s_q.vol_r))
    else $error("volume applied without update");
  a_volume_pair: assert property (clk_en && reg_wr && reg_addr == ADDR_RIGHT_DIGITAL_VOLUME
    && reg_wdata[BIT_VOL_UPDATE] |=> s_q.vol_r == $past(reg_wdata[7:0])
    && s_q.vol_l == $past(s_q.pend_l)) else $error("volume pair not applied");
  a_mute_down: assert property (clk_en && s_q.mute && ramp_tick && s_q.cur_l != 8'h00
    |=> s_q.cur_l == $past(s_q.cur_l) - 8'h01) else $error("mute ramp step wrong");
  a_mute_read: assert property (clk_en && reg_rd && reg_addr == ADDR_SOFT_MUTE_CONTROL
    |=> reg_rvalid && reg_rdata[BIT_SOFT_MUTE] == $past(s_q.mute)) else $error("mute readback");
  a_instant_unmute: assert property (clk_en && !s_q.mute && !s_q.ramp_mode
    |=> s_q.cur_r == $past(s_q.vol_r)) else $error("unmute not immediate");
  a_ramp_up: assert property (clk_en && !s_q.mute && s_q.ramp_mode && ramp_tick
    && s_q.cur_l < s_q.vol_l |=> s_q.cur_l == $past(s_q.cur_l) + 8'h01)
    else $error("unmute ramp step wrong");
  a_ramp_rate: assert property (ramp_tick
    |-> in_valid && s_q.tick_cnt >= (s_q.rate_slow ? 5'h1F : 5'h01)) else $error("ramp rate");
  a_mono_equal: assert property (clk_en && in_valid && mono_active
    && s_q.cur_l == s_q.cur_r && s_q.inv_l == s_q.inv_r |=> out_left == out_right)
    else $error("mono channels differ");
  a_step_hold: assert property (clk_en && !ramp_tick && (s_q.mute || s_q.ramp_mode)
    |=> $stable(s_q.cur_l)) else $error("gain moved off tick");
  c_ramp_to_zero: cover property (s_q.mute && s_q.cur_l == 8'h01 ##1 s_q.cur_l == 8'h00);
  c_volume_update: cover property (clk_en && reg_wr && reg_wdata[BIT_VOL_UPDATE]);
  c_mono_sample: cover property (clk_en && in_valid && mono_active);
  c_ramp_up_done: cover property (!s_q.mute && s_q.ramp_mode && s_q.cur_l == s_q.vol_l);
endmodule

// File: tb/audio_source.sv
`timescale 1ns/1ps

module audio_source
#(
  parameter int W = 24
)
(
  // clock
  input  logic                core_clk,
  // samples toward the path
  output logic                in_valid,
  output logic signed [W-1:0] in_left,
  output logic signed [W-1:0] in_right,
  // processed samples back
  input  logic                out_valid,
  input  logic signed [W-1:0] out_left,
  input  logic signed [W-1:0] out_right
);
  initial
  begin
    in_valid = 1'h0;
    in_left  = '0;
    in_right = '0;
  end

  // one frame; released lines show the inverse
  task automatic send(input logic signed [W-1:0] l, input logic signed [W-1:0] r,
                      output logic v, output logic signed [W-1:0] ol,
                      output logic signed [W-1:0] orr);
    @(posedge core_clk);
    in_valid <= 1'h1;
    in_left  <= l;
    in_right <= r;
    @(posedge core_clk);
    in_valid <= 1'h0;
    in_left  <= ~l;
    in_right <= ~r;
    #1;
    v   = out_valid;
    ol  = out_left;
    orr = out_right;
  endtask
endmodule

// File: tb/tb.sv
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, (a), (b)); end end

module tb;
  import dac_path_pkg::*;

  // ********
  // signals
  // ********
  logic               core_clk, reset_n, clk_en, reg_wr, reg_rd, reg_rvalid;
  logic        [7:0]  reg_addr;
  logic        [15:0] reg_wdata, reg_rdata;
  logic               in_valid, out_valid, sv;
  logic signed [23:0] in_left, in_right, out_left, out_right, sl, sr;
  logic               left_conv_enable, right_conv_enable, sloping_stopband_select;
  logic        [1:0]  deemphasis_select;
  int                 fails, check_count;

  stereo_dac_digital_path #(.W(24)) DUT
  (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right),
    .left_conv_enable(left_conv_enable), .right_conv_enable(right_conv_enable),
    .deemphasis_select(deemphasis_select), .sloping_stopband_select(sloping_stopband_select)
  );

  audio_source #(.W(24)) src
  (
    .core_clk(core_clk), .in_valid(in_valid), .in_left(in_left), .in_right(in_right),
    .out_valid(out_valid), .out_left(out_left), .out_right(out_right)
  );

  // ********
  // helpers
  // ********
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    `CHK(reg_rvalid, 1'h1)
    `CHK(reg_rdata, e)
  endtask

  task automatic play(input logic signed [23:0] l, r, el, er);
    src.send(l, r, sv, sl, sr);
    `CHK(sv, 1'h1)
    `CHK(sl, el)
    `CHK(sr, er)
  endtask

  // ********
  // scenarios
  // ********
  // reset values
  task automatic reset_values();
    logic [7:0]  a [7] = '{8'h0B, 8'h30, 8'h32, 8'h33, 8'h3A, 8'h3B, 8'h40};
    logic [15:0] e [7] = '{16'h0000, 16'h0000, 16'h00C0, 16'h00C0, 16'h4000, 16'h0000, 16'h0000};
    for (int i = 0; i < 7; i++)
      rd(a[i], e[i]);
    `CHK(left_conv_enable, 1'h0)
  endtask

  task automatic enable_alias();
    wr(ADDR_POWER_MANAGEMENT_4, 16'h0030);
    rd(ADDR_LEFT_DIGITAL_VOLUME, 16'h80C0);
    rd(ADDR_RIGHT_DIGITAL_VOLUME, 16'h80C0);
    `CHK({left_conv_enable, right_conv_enable}, 2'h3)
    wr(ADDR_LEFT_DIGITAL_VOLUME, 16'h00C0);
    rd(ADDR_POWER_MANAGEMENT_4, 16'h0020);
    @(posedge core_clk);
    clk_en <= 1'h0;
    wr(ADDR_POWER_MANAGEMENT_4, 16'h0030);
    @(posedge core_clk);
    clk_en <= 1'h1;
    rd(ADDR_POWER_MANAGEMENT_4, 16'h0020);
    wr(ADDR_POWER_MANAGEMENT_4, 16'h0030);
  endtask

  task automatic deferred_volume();
    wr(ADDR_SOFT_MUTE_CONTROL, 16'h0000);
    idle(2);
    play(24'sh100000, -24'sh080000, 24'sh100000, -24'sh080000);
    wr(ADDR_LEFT_DIGITAL_VOLUME, 16'h80A0);
    idle(2);
    play(24'sh100000, 24'sh100000, 24'sh100000, 24'sh100000);
    wr(ADDR_RIGHT_DIGITAL_VOLUME, 16'h8180);
    idle(2);
    play(24'sh100000, 24'sh100000, 24'sh040000, 24'sh010000);
    rd(ADDR_LEFT_DIGITAL_VOLUME, 16'h80A0);
    wr(ADDR_LEFT_DIGITAL_VOLUME, 16'h8100);
    idle(2);
    play(24'sh100000, 24'sh100000, 24'sh000000, 24'sh010000);
    wr(ADDR_LEFT_DIGITAL_VOLUME, 16'h80C0);
    wr(ADDR_RIGHT_DIGITAL_VOLUME, 16'h81C0);
    idle(2);
  endtask

  task automatic phase_and_mono();
    wr(ADDR_CONVERTER_CONTROL, 16'h0002);
    idle(2);
    play(24'sh100000, 24'sh080000, 24'shF00000, 24'sh080000);
    wr(ADDR_CONVERTER_CONTROL, 16'h0001);
    idle(2);
    play(24'sh100000, 24'sh800000, 24'sh100000, 24'sh7FFFFF);
    // both channels stay enabled for mono
    wr(ADDR_CONVERTER_CONTROL, 16'h2000);
    idle(2);
    play(24'sh100000, 24'sh080000, 24'sh0C0000, 24'sh0C0000);
    wr(ADDR_CONVERTER_CONTROL, 16'h0000);
  endtask

  task automatic filter_controls();
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CONVERTER_CONTROL, 16'(i << 4));
      idle(2);
      `CHK(deemphasis_select, 2'(i))
    end
    wr(ADDR_MUTE_RAMP_FILTER_CFG, 16'h1000);
    idle(2);
    `CHK(sloping_stopband_select, 1'h1)
    rd(ADDR_MUTE_RAMP_FILTER_CFG, 16'h1000);
    wr(ADDR_MUTE_RAMP_FILTER_CFG, 16'h0000);
    idle(2);
    `CHK(sloping_stopband_select, 1'h0)
  endtask

  task automatic mute_ramps();
    int                 n;
    logic               mono_ok;
    logic signed [23:0] prev, first;
    wr(ADDR_SOFT_MUTE_CONTROL, 16'h4000);
    n = 0;
    prev = 24'sh100000;
    mono_ok = 1'h1;
    do
    begin
      src.send(24'sh100000, 24'sh100000, sv, sl, sr);
      if (sl > prev)
        mono_ok = 1'h0;
      prev = sl;
      n++;
    end
    while (sl !== 24'sh000000 && n < 600);
    `CHK(mono_ok, 1'h1)
    `CHK(n >= 380 && n <= 392, 1'h1)
    // ramped unmute for a pause mid-track
    wr(ADDR_MUTE_RAMP_FILTER_CFG, 16'h6000);
    wr(ADDR_SOFT_MUTE_CONTROL, 16'h0000);
    n = 0;
    first = 24'sh000000;
    do
    begin
      src.send(24'sh100000, 24'sh100000, sv, sl, sr);
      if (n == 0)
        first = sl;
      if (sl < prev)
        mono_ok = 1'h0;
      prev = sl;
      n++;
    end
    while (sl !== 24'sh100000 && n < 6400);
    `CHK(first < 24'sh100000, 1'h1)
    `CHK(mono_ok, 1'h1)
    `CHK(n >= 6130 && n <= 6160, 1'h1)
  endtask

  // ********
  // run
  // ********
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    #200000;
    fails++;
    final_report();
  end

  initial
  begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'h1;
    reset_values();
    enable_alias();
    deferred_volume();
    phase_and_mono();
    filter_controls();
    mute_ramps();
    final_report();
  end
endmodule
